// ===== txc_defs.vh
// Purpose: Constants for the transmit TDM channel context block.
// Assumes: Included by bare name; holds definitions only.
// Notes:   Offsets are byte addresses on the AHB-Lite register bus.
`ifndef TXC_DEFS_VH
`define TXC_DEFS_VH

// ****************************************
// Register offsets
// ****************************************
`define TXC_OFF_CTRL     8'h00
`define TXC_OFF_BUF      8'h04
`define TXC_OFF_ADDR     8'h08
`define TXC_OFF_STATE    8'h0C
`define TXC_OFF_WROFF    8'h10
`define TXC_OFF_RDPTR    8'h14
`define TXC_OFF_STATUS   8'h18

// ****************************************
// Control register fields
// ****************************************
`define TXC_C_EN         0
`define TXC_C_HDLC       1
`define TXC_C_NIB        2
`define TXC_C_IL         3
`define TXC_C_OL         4
`define TXC_C_COMP_LO    5
`define TXC_C_PAIR       8
`define TXC_C_BSZ_LO     9
`define TXC_C_STYLE      12
`define TXC_C_HDR_LO     13
`define TXC_C_CRC        16
`define TXC_CTRL_W       17

// ****************************************
// Codes and reset values
// ****************************************
`define TXC_COMP_PCM     3'h0
`define TXC_COMP_A40     3'h1
`define TXC_COMP_A32     3'h2
`define TXC_COMP_A24     3'h3
`define TXC_COMP_A16     3'h4
`define TXC_COMP_AUTO_A  3'h5
`define TXC_COMP_AUTO_AP 3'h6
`define TXC_HDR_NONE     3'h0
`define TXC_HDR_A1       3'h1
`define TXC_HDR_A2       3'h2
`define TXC_HDR_A1C      3'h3
`define TXC_HDR_A2C      3'h4
`define TXC_ONES_INIT    3'h7
`define TXC_HIST_INIT    8'h01
`define TXC_FLAG_BYTE    8'h7E
`define TXC_ESC_BYTE     8'h7D
`define TXC_ESC_XOR      8'h20
`define TXC_LAW_XOR      8'h2A
`define TXC_CRC_INIT     16'hFFFF
`define TXC_CRC_POLY     16'h8408
`define TXC_CRC_GOOD     16'hF0B8
`define TXC_BUF_MIN      21'h0_0100
`define TXC_SOP_ALIGN    21'h0_001F

`endif

// ===== txc_bit_step.v
// Purpose: One bit step of bit-oriented HDLC de-framing.
// Assumes: Pure combinational; the caller holds the ones count and history.
// Notes:   History keeps a marker bit above the pending data bits.
`timescale 1ns/100ps
`include "txc_defs.vh"

module txc_bit_step (
	input  wire       bit_in,
	input  wire [2:0] ones,
	input  wire [7:0] hist,
	output reg  [2:0] next_ones,
	output reg  [7:0] next_hist,
	output reg        byte_ok,
	output wire [7:0] byte_out,
	output reg        flag,
	output reg        abort,
	output wire       aligned
);

	assign byte_out = {hist[6:0], bit_in};
	// A closing flag leaves exactly seven pending bits when the frame ended on a byte boundary.
	assign aligned = hist[7];

	always @* begin
		next_ones = ones;
		next_hist = hist;
		byte_ok = 1'b0;
		flag = 1'b0;
		abort = 1'b0;
		if (bit_in) begin
			if (ones != 3'h7) begin
				next_ones = ones + 3'h1;
			end
			if (ones >= 3'h6) begin
				abort = (ones == 3'h6);
				next_hist = `TXC_HIST_INIT;
			end else if (hist[7]) begin
				byte_ok = 1'b1;
				next_hist = `TXC_HIST_INIT;
			end else begin
				next_hist = {hist[6:0], bit_in};
			end
		end else begin
			next_ones = 3'h0;
			if (ones == 3'h5) begin
				next_hist = hist;
			end else if (ones == 3'h6) begin
				flag = 1'b1;
				next_hist = `TXC_HIST_INIT;
			end else if (ones == 3'h7) begin
				next_hist = `TXC_HIST_INIT;
			end else if (hist[7]) begin
				byte_ok = 1'b1;
				next_hist = `TXC_HIST_INIT;
			end else begin
				next_hist = {hist[6:0], bit_in};
			end
		end
	end

endmodule

// ===== txc_channel_context.v
// Purpose: Transmit TDM channel context: PCM/ADPCM buffer or HDLC stream de-framing.
// Assumes: One clock; TDM pins are asynchronous and are synchronised here.
// Notes:   Software writes win over hardware context updates in the same cycle.
// Notes on behaviour
// - PCM buffer base and size from one field.
// - Nibble bit: 0 upper, 1 lower ADPCM bits.
// - Input law bit: 0 mu-law, 1 A-law.
// - Output law bit; translate when laws differ.
// - Compression code selects PCM or ADPCM rate.
// - Code 101 autodetect ADPCM, unpaired; 111 reserved.
// - Code 110 autodetect both, paired stream required.
// - HDLC field holds base and start pointer.
// - Record HDLC address of current frame.
// - Count received header bytes of frame.
// - Write offset relative to start pointer.
// - Read pointer advanced by assembly logic.
// - Buffer size code: 256 bytes doubling to 32K.
// - Framing style: 0 bitwise, 1 bytewise.
// - CRC bit expects trailing CRC16 per frame.
// - Keep consecutive ones count per stream.
// - History holds pending bits under marker bit.
// - Paired stream reads even and odd streams.
// - Post event on each completed frame; one failing the alignment, length or CRC check sets a sticky flag instead.
`timescale 1ns/100ps
`include "txc_defs.vh"

module txc_channel_context (
	input  wire        clk,
	input  wire        rst,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	input  wire        tdm_clk,
	input  wire        tdm_fsync,
	input  wire        tdm_even,
	input  wire        tdm_odd,
	output reg         mem_we,
	output reg  [20:0] mem_addr,
	output reg  [7:0]  mem_wdata,
	output reg         evt_valid,
	output reg  [20:0] evt_start,
	output reg  [14:0] evt_len,
	output reg  [15:0] evt_addr
);

	// ****************************************
	// Context and status registers
	// ****************************************
	reg  [`TXC_CTRL_W-1:0] ctrl;
	reg  [15:0] ctx_buf;
	reg  [15:0] ctx_addr;
	reg  [1:0]  header_byte_counter;
	reg  [2:0]  ctx_ones;
	reg  [7:0]  ctx_hist;
	reg  [14:0] ctx_wroff;
	reg  [14:0] ctx_rdptr;
	reg  [2:0]  sticky;
	reg  [7:0]  frame_cnt;
	reg  [15:0] crc;
	reg         hunt;
	reg         esc;
	reg         dp_wr;
	reg  [7:0]  dp_addr;

	wire        ch_en                  = ctrl[`TXC_C_EN];
	wire        ch_hdlc                = ctrl[`TXC_C_HDLC];
	wire        nibble_low             = ctrl[`TXC_C_NIB];
	wire        input_law_select       = ctrl[`TXC_C_IL];
	wire        output_law_select      = ctrl[`TXC_C_OL];
	wire [2:0]  comp                   = ctrl[`TXC_C_COMP_LO+2:`TXC_C_COMP_LO];
	wire        paired_stream_enable   = ctrl[`TXC_C_PAIR];
	wire [2:0]  buf_size               = ctrl[`TXC_C_BSZ_LO+2:`TXC_C_BSZ_LO];
	wire        framing_style_select   = ctrl[`TXC_C_STYLE];
	wire [2:0]  hdr_type               = ctrl[`TXC_C_HDR_LO+2:`TXC_C_HDR_LO];
	wire        crc_on                 = ctrl[`TXC_C_CRC];

	// ****************************************
	// Link sampling
	// ****************************************
	reg  [3:0]  sync1;
	reg  [3:0]  sync2;
	reg         clk_d;
	reg  [3:0]  bit_pos;
	reg  [7:0]  sr_even;
	reg  [7:0]  sr_odd;
	reg         cap_done;

	wire        link_rise = sync2[0] & ~clk_d;

	// The first stage is read only by the second, so a metastable pin never reaches logic.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
			clk_d <= 1'b0;
			bit_pos <= 4'h0;
			sr_even <= 8'h00;
			sr_odd <= 8'h00;
			cap_done <= 1'b0;
		end else begin
			sync1 <= {tdm_odd, tdm_even, tdm_fsync, tdm_clk};
			sync2 <= sync1;
			clk_d <= sync2[0];
			cap_done <= 1'b0;
			if (link_rise) begin
				sr_even <= {sr_even[6:0], sync2[2]};
				sr_odd <= {sr_odd[6:0], sync2[3]};
				if (sync2[1]) begin
					bit_pos <= 4'h1;
				end else if (bit_pos == 4'h7) begin
					bit_pos <= 4'h0;
					cap_done <= 1'b1;
				end else if (bit_pos != 4'h0) begin
					bit_pos <= bit_pos + 4'h1;
				end
			end
		end
	end

	// ****************************************
	// Byte engine: even byte first, then odd
	// ****************************************
	reg  [7:0]  work;
	reg  [3:0]  work_cnt;
	reg  [7:0]  odd_byte;
	reg         odd_pend;

	wire        bitwise = ch_hdlc & ~framing_style_select;
	wire        busy    = (work_cnt != 4'h0);
	wire [3:0]  load_cnt = bitwise ? 4'h8 : 4'h1;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			work <= 8'h00;
			work_cnt <= 4'h0;
			odd_byte <= 8'h00;
			odd_pend <= 1'b0;
		end else if (cap_done && ch_en && !busy) begin
			work <= sr_even;
			work_cnt <= load_cnt;
			odd_byte <= sr_odd;
			odd_pend <= paired_stream_enable;
		end else if (busy) begin
			work <= {work[6:0], 1'b0};
			work_cnt <= work_cnt - 4'h1;
			if (work_cnt == 4'h1 && odd_pend) begin
				work <= odd_byte;
				work_cnt <= load_cnt;
				odd_pend <= 1'b0;
			end
		end
	end

	// ****************************************
	// De-framing decisions
	// ****************************************
	wire [2:0]  s_ones;
	wire [7:0]  s_hist;
	wire        s_ok;
	wire [7:0]  s_byte;
	wire        s_flag;
	wire        s_abort;
	wire        s_aligned;

	txc_bit_step u_step (
		.bit_in    (work[7]),
		.ones      (ctx_ones),
		.hist      (ctx_hist),
		.next_ones (s_ones),
		.next_hist (s_hist),
		.byte_ok   (s_ok),
		.byte_out  (s_byte),
		.flag      (s_flag),
		.abort     (s_abort),
		.aligned   (s_aligned)
	);

	wire        b_flag = (work == `TXC_FLAG_BYTE);
	wire        b_esc  = (work == `TXC_ESC_BYTE) & ~esc;
	reg         dv;
	reg  [7:0]  db;
	reg         fl;
	reg         ab;
	reg  [1:0]  hlen;
	reg  [1:0]  nadr;

	always @* begin
		dv = 1'b0;
		db = work;
		fl = 1'b0;
		ab = 1'b0;
		if (busy && ch_hdlc) begin
			if (bitwise) begin
				dv = s_ok;
				db = s_byte;
				fl = s_flag;
				ab = s_abort;
			end else begin
				fl = b_flag & ~esc;
				ab = b_flag & esc;
				dv = ~b_flag & ~b_esc;
				db = esc ? (work ^ `TXC_ESC_XOR) : work;
			end
		end
		case (hdr_type)
			`TXC_HDR_A1: begin
				hlen = 2'd1;
				nadr = 2'd1;
			end
			`TXC_HDR_A2: begin
				hlen = 2'd2;
				nadr = 2'd2;
			end
			`TXC_HDR_A1C: begin
				hlen = 2'd2;
				nadr = 2'd1;
			end
			`TXC_HDR_A2C: begin
				hlen = 2'd3;
				nadr = 2'd2;
			end
			default: begin
				hlen = 2'd0;
				nadr = 2'd0;
			end
		endcase
	end

	// ****************************************
	// Buffer addressing
	// ****************************************
	wire [20:0] h_mask  = (`TXC_BUF_MIN << buf_size) - 21'h0_0001;
	wire [20:0] h_full  = {ctx_buf, 5'h00};
	wire [20:0] h_base  = h_full & ~h_mask;
	wire [20:0] h_sop   = h_full & h_mask;
	wire [20:0] h_off   = {6'h00, ctx_wroff};
	wire [20:0] h_waddr = h_base | ((h_sop + h_off) & h_mask);
	wire [20:0] h_next  = ((h_sop + h_off + `TXC_SOP_ALIGN) & h_mask) & ~`TXC_SOP_ALIGN;
	wire [20:0] h_field = h_base | h_next;
	wire [1:0]  p_sz    = (ctx_buf[1:0] == 2'h3) ? 2'h2 : ctx_buf[1:0];
	wire [20:0] p_mask  = (`TXC_BUF_MIN << p_sz) - 21'h0_0001;
	wire [20:0] p_waddr = ({ctx_buf[15:3], 8'h00} & ~p_mask) | (h_off & p_mask);
	wire [14:0] min_len = {13'h0000, hlen} + (crc_on ? 15'h0002 : 15'h0000);

	// Law translation by a fixed bit pattern; segment edges may land one step off.
	wire [7:0]  law_out = (input_law_select != output_law_select) ? (work ^ `TXC_LAW_XOR) : work;
	reg  [7:0]  pcm_byte;
	reg  [7:0]  nib_mask;
	// Low placement keeps the same number of sample bits, mirrored to the bottom of the byte.
	wire [7:0]  nib_low_mask = {nib_mask[0], nib_mask[1], nib_mask[2], nib_mask[3],
	                            nib_mask[4], nib_mask[5], nib_mask[6], nib_mask[7]};

	always @* begin
		case (comp)
			`TXC_COMP_A40: nib_mask = 8'hF8;
			`TXC_COMP_A32: nib_mask = 8'hF0;
			`TXC_COMP_A24: nib_mask = 8'hE0;
			`TXC_COMP_A16: nib_mask = 8'hC0;
			default:       nib_mask = 8'hFF;
		endcase
		if (comp == `TXC_COMP_PCM) begin
			pcm_byte = law_out;
		end else if (comp == `TXC_COMP_AUTO_A || comp == `TXC_COMP_AUTO_AP) begin
			pcm_byte = work;
		end else if (nibble_low) begin
			pcm_byte = work & nib_low_mask;
		end else begin
			pcm_byte = work & nib_mask;
		end
	end

	function [15:0] crc_byte;
		input [15:0] c;
		input [7:0]  d;
		integer i;
		reg [15:0] r;
		begin
			r = c;
			for (i = 0; i < 8; i = i + 1) begin
				if (r[0] ^ d[i]) begin
					r = (r >> 1) ^ `TXC_CRC_POLY;
				end else begin
					r = r >> 1;
				end
			end
			crc_byte = r;
		end
	endfunction

	wire        frame_end = fl & ~hunt & (ctx_wroff != 15'h0000);
	wire        bad_align = bitwise & ~s_aligned;
	wire        bad_short = (ctx_wroff <= min_len);
	wire        bad_crc   = crc_on & (crc != `TXC_CRC_GOOD);

	// ****************************************
	// Context update and register writes
	// ****************************************
	wire        ap_take = hsel & htrans[1] & hready;

	// Software writes come last so an initialising write wins over hardware, except a STATUS clear, which a flag raised in the same cycle survives.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl <= {`TXC_CTRL_W{1'b0}};
			ctx_buf <= 16'h0000;
			ctx_addr <= 16'h0000;
			header_byte_counter <= 2'h0;
			ctx_ones <= `TXC_ONES_INIT;
			ctx_hist <= `TXC_HIST_INIT;
			ctx_wroff <= 15'h0000;
			ctx_rdptr <= 15'h0000;
			sticky <= 3'h0;
			frame_cnt <= 8'h00;
			crc <= `TXC_CRC_INIT;
			hunt <= 1'b1;
			esc <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= 21'h00_0000;
			mem_wdata <= 8'h00;
			evt_valid <= 1'b0;
			evt_start <= 21'h00_0000;
			evt_len <= 15'h0000;
			evt_addr <= 16'h0000;
			dp_wr <= 1'b0;
			dp_addr <= 8'h00;
		end else begin
			mem_we <= 1'b0;
			evt_valid <= 1'b0;
			dp_wr <= ap_take & hwrite;
			if (ap_take) begin
				dp_addr <= haddr[7:0];
			end
			if (busy && !ch_hdlc) begin
				mem_we <= 1'b1;
				mem_addr <= p_waddr;
				mem_wdata <= pcm_byte;
				ctx_wroff <= (ctx_wroff + 15'h0001) & p_mask[14:0];
			end
			if (busy && ch_hdlc) begin
				if (bitwise) begin
					ctx_ones <= s_ones;
					ctx_hist <= s_hist;
				end else begin
					esc <= b_esc;
				end
				if (dv && !hunt) begin
					mem_we <= 1'b1;
					mem_addr <= h_waddr;
					mem_wdata <= db;
					ctx_wroff <= ctx_wroff + 15'h0001;
					crc <= crc_byte(crc, db);
					if (header_byte_counter < hlen) begin
						header_byte_counter <= header_byte_counter + 2'h1;
					end
					if (header_byte_counter < nadr) begin
						ctx_addr <= {ctx_addr[7:0], db};
					end
				end
				if (fl || ab) begin
					ctx_wroff <= 15'h0000;
					header_byte_counter <= 2'h0;
					ctx_addr <= 16'h0000;
					crc <= `TXC_CRC_INIT;
					esc <= 1'b0;
					hunt <= ab;
				end
				if (ab && !hunt) begin
					sticky[1] <= 1'b1;
				end
				if (frame_end) begin
					if (bad_align || bad_short) begin
						sticky[2] <= 1'b1;
					end else if (bad_crc) begin
						sticky[0] <= 1'b1;
					end else begin
						evt_valid <= 1'b1;
						evt_start <= h_base | h_sop;
						evt_len <= ctx_wroff;
						evt_addr <= ctx_addr;
						frame_cnt <= frame_cnt + 8'h01;
						ctx_buf <= h_field[20:5];
					end
				end
			end
			if (dp_wr) begin
				case (dp_addr)
					`TXC_OFF_CTRL:   ctrl <= hwdata[`TXC_CTRL_W-1:0];
					`TXC_OFF_BUF:    ctx_buf <= hwdata[15:0];
					`TXC_OFF_ADDR:   ctx_addr <= hwdata[15:0];
					`TXC_OFF_STATE: begin
						header_byte_counter <= hwdata[1:0];
						ctx_ones <= hwdata[6:4];
						ctx_hist <= hwdata[15:8];
					end
					`TXC_OFF_WROFF:  ctx_wroff <= hwdata[14:0];
					`TXC_OFF_RDPTR:  ctx_rdptr <= hwdata[14:0];
					`TXC_OFF_STATUS: begin
						// A flag raised in this same cycle survives the clear.
						sticky[0] <= sticky[0] & ~hwdata[0] | (frame_end & ~bad_align & ~bad_short & bad_crc);
						sticky[1] <= sticky[1] & ~hwdata[1] | (busy & ch_hdlc & ab & ~hunt);
						sticky[2] <= sticky[2] & ~hwdata[2] | (frame_end & (bad_align | bad_short));
					end
					default: begin
						ctrl <= ctrl;
					end
				endcase
			end
		end
	end

	// ****************************************
	// AHB-Lite read data
	// ****************************************
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always @* begin
		case (dp_addr)
			`TXC_OFF_CTRL:   hrdata = {{(32-`TXC_CTRL_W){1'b0}}, ctrl};
			`TXC_OFF_BUF:    hrdata = {16'h0000, ctx_buf};
			`TXC_OFF_ADDR:   hrdata = {16'h0000, ctx_addr};
			`TXC_OFF_STATE:  hrdata = {16'h0000, ctx_hist, 1'b0, ctx_ones, 2'h0, header_byte_counter};
			`TXC_OFF_WROFF:  hrdata = {17'h0_0000, ctx_wroff};
			`TXC_OFF_RDPTR:  hrdata = {17'h0_0000, ctx_rdptr};
			`TXC_OFF_STATUS: hrdata = {16'h0000, frame_cnt, 5'h00, sticky};
			default:         hrdata = 32'h0000_0000;
		endcase
	end

endmodule

// ===== txc_ctx_props.sv
// Purpose: Port checker for the transmit channel context.
// Assumes: One clock, one AHB-Lite master, zero wait states.
// Notes:   CTRL and BUF are shadowed from bus writes, so the checker needs no internal signals.
`timescale 1ns/100ps
module txc_ctx_props (
	input wire        clk,
	input wire        rst,
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire [31:0] hwdata,
	input wire        hready,
	input wire        mem_we,
	input wire [20:0] mem_addr,
	input wire [7:0]  mem_wdata,
	input wire        evt_valid,
	input wire [20:0] evt_start,
	input wire [14:0] evt_len
);
	// ****************************************
	// Shadow registers
	// ****************************************
	reg        ap_wr;
	reg [7:0]  ap_a;
	reg [16:0] sh_ctrl;
	reg [15:0] sh_buf;
	wire [2:0] hdr_c = sh_ctrl[15:13];
	wire [2:0] hdr_n = (hdr_c == 3'h0) ? 3'h0 : (hdr_c == 3'h1) ? 3'h1 : (hdr_c == 3'h4) ? 3'h3 : 3'h2;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ap_wr   <= 1'b0;
			ap_a    <= 8'h00;
			sh_ctrl <= 17'h0_0000;
			sh_buf  <= 16'h0000;
		end else begin
			ap_wr <= hsel && htrans[1] && hready && hwrite;
			ap_a  <= haddr[7:0];
			if (ap_wr && ap_a == 8'h00)
				sh_ctrl <= hwdata[16:0];
			if (ap_wr && ap_a == 8'h04)
				sh_buf <= hwdata[15:0];
		end
	end
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_ctrl_off;
		hsel && htrans[1] && hready && hwrite && haddr[7:0] == 8'h00 ##1 !hwdata[0];
	endsequence
	a_idle_silent: assert property (mem_we |-> sh_ctrl[0])
		else $error("Buffer write while the channel is disabled.");
	a_off_quiet: assert property (s_ctrl_off |=> !mem_we [*8])
		else $error("Buffer write after the channel was disabled.");
	a_pcm_base: assert property (mem_we && !sh_ctrl[1] && sh_buf[1:0] == 2'b00 |-> mem_addr[20:8] == sh_buf[15:3])
		else $error("Buffer write outside the programmed base.");
	a_nibble_place: assert property (mem_we && !sh_ctrl[1] && sh_ctrl[7:5] == 3'h2
		|-> (sh_ctrl[2] ? mem_wdata[7:4] == 4'h0 : mem_wdata[3:0] == 4'h0))
		else $error("Sample bits on the wrong side of the byte.");
	a_evt_pulse: assert property ($rose(evt_valid) |=> !evt_valid)
		else $error("Frame event longer than one cycle.");
	a_evt_hdlc: assert property (evt_valid |-> sh_ctrl[1] && sh_ctrl[0])
		else $error("Frame event on a channel that is not an enabled stream.");
	a_sop_align: assert property (evt_valid |-> evt_start[4:0] == 5'h00)
		else $error("Frame start not on a 32 byte boundary.");
	a_hdr_len: assert property (evt_valid |-> evt_len > {12'h000, hdr_n})
		else $error("Frame shorter than its header.");
endmodule

bind txc_channel_context txc_ctx_props txc_ctx_props_inst (
	.clk       (clk),
	.rst       (rst),
	.hsel      (hsel),
	.haddr     (haddr),
	.htrans    (htrans),
	.hwrite    (hwrite),
	.hwdata    (hwdata),
	.hready    (hready),
	.mem_we    (mem_we),
	.mem_addr  (mem_addr),
	.mem_wdata (mem_wdata),
	.evt_valid (evt_valid),
	.evt_start (evt_start),
	.evt_len   (evt_len)
);

// ===== txc_tdm_model.sv
// Purpose: Behavioural TDM backplane source for one channel timeslot.
// Assumes: Link clock of 200 ns that stands still outside the timeslot.
// Notes:   Released data lines show the inverse of the last bit.
`timescale 1ns/100ps
module txc_tdm_model (
	output reg tdm_clk,
	output reg tdm_fsync,
	output reg tdm_even,
	output reg tdm_odd
);
	initial begin
		tdm_clk   = 1'b0;
		tdm_fsync = 1'b0;
		tdm_even  = 1'b0;
		tdm_odd   = 1'b0;
	end
	// The 7 ns lead keeps link edges off the system clock edges.
	task send(input [7:0] ev, input [7:0] od);
		integer i;
		begin
			#7;
			for (i = 7; i >= 0; i = i - 1) begin
				tdm_fsync = (i == 7);
				tdm_even  = ev[i];
				tdm_odd   = od[i];
				#100 tdm_clk = 1'b1;
				#100 tdm_clk = 1'b0;
			end
			tdm_fsync = 1'b0;
			tdm_even  = ~tdm_even;
			tdm_odd   = ~tdm_odd;
		end
	endtask
endmodule

// ===== tb_txc_channel_context.sv
// Purpose: Self-checking bench for the transmit channel context.
// Assumes: Zero-wait AHB-Lite slave; the partner model drives the TDM pins.
// Notes:   Buffer base 0x12300 of 256 bytes for every case.
`timescale 1ns/100ps
module tb_txc_channel_context;
	reg         clk;
	reg         rst;
	reg         hsel;
	reg  [31:0] haddr;
	reg  [1:0]  htrans;
	reg         hwrite;
	reg  [2:0]  hsize;
	reg  [31:0] hwdata;
	wire        hready;
	wire        hresp;
	wire [31:0] hrdata;
	wire        tdm_clk;
	wire        tdm_fsync;
	wire        tdm_even;
	wire        tdm_odd;
	wire        mem_we;
	wire [20:0] mem_addr;
	wire [7:0]  mem_wdata;
	wire        evt_valid;
	wire [20:0] evt_start;
	wire [14:0] evt_len;
	wire [15:0] evt_addr;
	integer     failures;
	integer     comparisons;
	integer     evts;
	integer     i;
	reg  [7:0]  off;
	reg  [28:0] wq[$];
	reg  [51:0] last_evt;
	reg  [55:0] frame;
	txc_channel_context txc_channel_context_inst (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .tdm_clk(tdm_clk), .tdm_fsync(tdm_fsync),
		.tdm_even(tdm_even), .tdm_odd(tdm_odd), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .evt_valid(evt_valid), .evt_start(evt_start), .evt_len(evt_len),
		.evt_addr(evt_addr));
	txc_tdm_model txc_tdm_model_inst (.tdm_clk(tdm_clk), .tdm_fsync(tdm_fsync), .tdm_even(tdm_even),
		.tdm_odd(tdm_odd));
	always #12.5 clk = ~clk;
	// Outputs are registered, so the falling edge sees them settled.
	always @(negedge clk) begin
		if (mem_we === 1'b1)
			wq.push_back({mem_addr, mem_wdata});
		if (evt_valid === 1'b1) begin
			evts = evts + 1;
			last_evt = {evt_start, evt_len, evt_addr};
		end
	end
	// ****************************************
	// Tasks
	// ****************************************
	task check(input [31:0] seen, input [31:0] exp, input [8*8-1:0] what);
		begin
			comparisons = comparisons + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("BAD %0t %0s seen %h expected %h", $time, what, seen, exp);
			end
		end
	endtask
	// Ready and read data are taken at the rising edge, before the design updates.
	task wait_rdy(output [31:0] d);
		begin
			@(posedge clk);
			while (hready !== 1'b1)
				@(posedge clk);
			d = hrdata;
		end
	endtask
	task xfer(input wr, input [7:0] a, input [31:0] wd, output [31:0] rd);
		begin
			@(posedge clk);
			hsel   <= 1'b1;
			haddr  <= {24'h00_0000, a};
			htrans <= 2'b10;
			hwrite <= wr;
			wait_rdy(rd);
			hsel   <= 1'b0;
			htrans <= 2'b00;
			hwdata <= wd;
			wait_rdy(rd);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		reg [31:0] x;
		xfer(1'b1, a, d, x);
	endtask
	task rd_chk(input [7:0] a, input [31:0] exp);
		reg [31:0] x;
		begin
			xfer(1'b0, a, 32'h0000_0000, x);
			check(x, exp, "register");
		end
	endtask
	task expect_we(input [7:0] exp);
		integer n;
		reg [28:0] w;
		begin
			n = 0;
			while (wq.size() == 0 && n < 60) begin
				@(posedge clk);
				n = n + 1;
			end
			w = (wq.size() > 0) ? wq.pop_front() : 29'h1FFF_FFFF;
			check({11'h000, w[28:8]}, {11'h000, 13'h0123, off}, "address");
			check({24'h00_0000, w[7:0]}, {24'h00_0000, exp}, "data");
			off = off + 8'h01;
		end
	endtask
	task pcm_case(input [16:0] ctrl, input [7:0] ev, input [7:0] od, input [7:0] exp_e, input [7:0] exp_o);
		begin
			wr(8'h00, {15'h0000, ctrl});
			txc_tdm_model_inst.send(ev, od);
			expect_we(exp_e);
			if (ctrl[8])
				expect_we(exp_o);
		end
	endtask
	task wait_evt(input integer n);
		integer k;
		begin
			k = 0;
			while (evts < n && k < 60) begin
				@(posedge clk);
				k = k + 1;
			end
		end
	endtask
	task conclude;
		begin
			$display("comparisons %0d failures %0d", comparisons, failures);
			if (failures == 0 && comparisons > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		#300000;
		failures = failures + 1;
		conclude;
	end
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		failures = 0;
		comparisons = 0;
		evts = 0;
		off = 8'h00;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rd_chk(8'h0C, 32'h0000_0170);
		rd_chk(8'h08, 32'h0000_0000);
		rd_chk(8'h10, 32'h0000_0000);
		rd_chk(8'h20, 32'h0000_0000);
		wr(8'h14, 32'hFFFF_FFFF);
		rd_chk(8'h14, 32'h0000_7FFF);
		wr(8'h04, 32'h0000_0918);
		rd_chk(8'h04, 32'h0000_0918);
		pcm_case(17'h0_0001, 8'hA5, 8'h00, 8'hA5, 8'h00);
		pcm_case(17'h0_0011, 8'hA5, 8'h00, 8'h8F, 8'h00);
		pcm_case(17'h0_0009, 8'hA5, 8'h00, 8'h8F, 8'h00);
		pcm_case(17'h0_0019, 8'hA5, 8'h00, 8'hA5, 8'h00);
		pcm_case(17'h0_0021, 8'hFF, 8'h00, 8'hF8, 8'h00);
		pcm_case(17'h0_0045, 8'hFF, 8'h00, 8'h0F, 8'h00);
		pcm_case(17'h0_0061, 8'hFF, 8'h00, 8'hE0, 8'h00);
		pcm_case(17'h0_0085, 8'hFF, 8'h00, 8'h03, 8'h00);
		pcm_case(17'h0_00A1, 8'h5A, 8'h00, 8'h5A, 8'h00);
		pcm_case(17'h0_01C1, 8'h3C, 8'hC3, 8'h3C, 8'hC3);
		wr(8'h10, 32'h0000_0000);
		wr(8'h0C, 32'h0000_0170);
		wr(8'h08, 32'h0000_0000);
		wr(8'h00, 32'h0000_3003);
		off = 8'h00;
		frame = 56'h7E_5511_7D5D_337E;
		for (i = 6; i >= 0; i = i - 1)
			txc_tdm_model_inst.send(frame[i*8 +: 8], 8'h00);
		expect_we(8'h55);
		expect_we(8'h11);
		expect_we(8'h7D);
		expect_we(8'h33);
		wait_evt(1);
		check(evts, 1, "events");
		check({11'h000, last_evt[51:31]}, 32'h0001_2300, "start");
		check({17'h0_0000, last_evt[30:16]}, 32'h0000_0004, "length");
		check({16'h0000, last_evt[15:0]}, 32'h0000_0055, "hdlcaddr");
		rd_chk(8'h04, 32'h0000_0919);
		rd_chk(8'h10, 32'h0000_0000);
		rd_chk(8'h0C, 32'h0000_0170);
		rd_chk(8'h18, 32'h0000_0100);
		// Bit-oriented frame: flag, two data bytes, flag, placed at the next 32 byte boundary.
		wr(8'h00, 32'h0000_2003);
		off = 8'h20;
		frame = 56'h00_0000_7E55_117E;
		for (i = 3; i >= 0; i = i - 1)
			txc_tdm_model_inst.send(frame[i*8 +: 8], 8'h00);
		expect_we(8'h55);
		expect_we(8'h11);
		wait_evt(2);
		check(evts, 2, "events");
		check({11'h000, last_evt[51:31]}, 32'h0001_2320, "start");
		check({17'h0_0000, last_evt[30:16]}, 32'h0000_0002, "length");
		rd_chk(8'h04, 32'h0000_091A);
		rd_chk(8'h0C, 32'h0000_0100);
		wr(8'h00, 32'h0000_0000);
		txc_tdm_model_inst.send(8'hA5, 8'h00);
		repeat (60) @(posedge clk);
		check(wq.size(), 0, "nowrite");
		conclude;
	end
endmodule
